// >>> design/mft_pkg.sv
package mft_pkg;

    // ****************************************************************
    // Register indices (printed offsets); byte address is index times 4
    // ****************************************************************
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_COUNTER_ONE = 8'h40;
    localparam logic [7:0] IDX_RELOAD_A = 8'h42;
    localparam logic [7:0] IDX_RELOAD_B = 8'h44;
    localparam logic [7:0] IDX_COUNTER_TWO = 8'h46;
    localparam logic [7:0] IDX_PRESCALE = 8'h48;
    localparam logic [7:0] IDX_CLOCK_SEL = 8'h4a;
    localparam logic [7:0] IDX_MODE_CTRL = 8'h4c;
    localparam logic [7:0] IDX_IRQ_CTRL = 8'h4e;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h50;

    // ****************************************************************
    // Mode control fields
    // ****************************************************************
    localparam int MODE_LSB = 0;
    localparam int POL_A_BIT = 2;
    localparam int POL_B_BIT = 3;
    localparam int EN_A_BIT = 4;
    localparam int EN_B_BIT = 5;
    localparam int LEVEL_A_BIT = 6;
    localparam int UNIT_EN_BIT = 7;
    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
    localparam logic [7:0] IRQ_CLEAR_READ = 8'hff;
    localparam logic [15:0] PRESET_VALUE = 16'hffff;

    // ****************************************************************
    // Prescaler and clock select fields
    // ****************************************************************
    localparam int PRESCALE_W = 5;
    localparam int SEL_W = 3;
    localparam int SEL2_LSB = 3;

    typedef enum logic [1:0] {
        MODE_PWM,
        MODE_DUAL_CAPTURE,
        MODE_DUAL_COUNTER,
        MODE_SINGLE_CAPTURE
    } mode_e;

    typedef enum logic [2:0] {
        CLK_NONE,
        CLK_PRESCALED,
        CLK_PIN_B_EVENT,
        CLK_PULSE_ACC,
        CLK_SLOW,
        CLK_RSV5,
        CLK_RSV6,
        CLK_RSV7
    } clk_sel_e;

endpackage

// >>> design/timer_mode_and_irq_control.sv
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ns

// Overview of operation
// - Two-bit field selects one of four modes
// - Pin A polarity clear falling, set rising
// - Dual capture: pin A edge presets counter one
// - Other modes: pin A enable makes PWM output
// - Disabled pin takes no part in capture or output
// - Pin B edge presets counter one or two
// - Pin B enable ignored in PWM, dual counter
// - Level bit follows PWM pin, software accessible
// - Software write beats hardware level update
// - Level bit inert while pin A is input
// - Unit disabled halts all counter clocking
// - Disabled unit ignores counter, reload, pending writes
// - Disabled clears prescaler, pending; pin A input
// - Mode control resets to all zeros
// - Four enable and four pending bits
// - Pending set by hardware or software one
// - Software zero to pending ignored
// - Clear register one clears pending, zero ignored
// - Request only when enable and pending both
// - Source A reload, or pin A capture
// - PWM pin toggles on counter one underflow
module timer_mode_and_irq_control (
    input wire logic pclk, // System clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, high for write
    input wire logic [mft_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic pin_a_i, // Pin A input level
    output logic pin_a_o, // Pin A output level
    output logic pin_a_oe, // Pin A output enable
    input wire logic pin_b_i, // Pin B input level
    input wire logic slow_tick, // Slow clock tick, one cycle pulse
    output logic irq_timer1, // Request from sources A, B, C
    output logic irq_timer2 // Request from source D
);
    import mft_pkg::*;

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [7:0] mode_ctrl_q;
    logic [7:0] irq_en_q;
    logic [3:0] pend_q;
    logic [3:0] pend_d;
    logic [PRESCALE_W-1:0] prescale_divisor_q;
    logic [PRESCALE_W-1:0] prescale_cnt_q;
    logic [2*SEL_W-1:0] clk_sel_q;
    logic [15:0] counter_one_q;
    logic [15:0] counter_two_q;
    logic [15:0] reload_a_q;
    logic [15:0] reload_b_q;
    logic pin_a_prev_q;
    logic pin_b_prev_q;
    logic reload_b_next_q;

    // ****************************************************************
    // Decode of fields and bus
    // ****************************************************************
    mode_e mode;
    logic unit_enable;
    logic pin_a_enable;
    logic pin_b_enable;
    logic pin_a_edge_polarity;
    logic pin_b_edge_polarity;
    logic pin_a_output_level;
    clk_sel_e sel_one;
    clk_sel_e sel_two;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic mapped;

    assign mode = mode_e'(mode_ctrl_q[MODE_LSB +: 2]);
    assign unit_enable = mode_ctrl_q[UNIT_EN_BIT];
    assign pin_a_enable = mode_ctrl_q[EN_A_BIT];
    assign pin_b_enable = mode_ctrl_q[EN_B_BIT];
    assign pin_a_edge_polarity = mode_ctrl_q[POL_A_BIT];
    assign pin_b_edge_polarity = mode_ctrl_q[POL_B_BIT];
    assign pin_a_output_level = mode_ctrl_q[LEVEL_A_BIT];
    assign sel_one = clk_sel_e'(clk_sel_q[0 +: SEL_W]);
    assign sel_two = clk_sel_e'(clk_sel_q[SEL2_LSB +: SEL_W]);

    // Word aligned access only; low two address bits are ignored
    assign idx = paddr[ADDR_W-1:2];
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign mapped = (idx == IDX_COUNTER_ONE) || (idx == IDX_COUNTER_TWO) ||
                    (idx == IDX_RELOAD_A) || (idx == IDX_RELOAD_B) ||
                    (idx == IDX_PRESCALE) || (idx == IDX_CLOCK_SEL) ||
                    (idx == IDX_MODE_CTRL) || (idx == IDX_IRQ_CTRL) ||
                    (idx == IDX_IRQ_CLEAR);
    assign pslverr = psel & penable & ~mapped;

    // Write strobes; unit enable gates off the counter and reload writes while halted
    logic wr_cnt1;
    logic wr_cnt2;
    logic wr_rel_a;
    logic wr_rel_b;
    logic wr_mode;
    logic wr_irq;
    logic wr_clr;
    assign wr_cnt1 = wr & (idx == IDX_COUNTER_ONE) & unit_enable;
    assign wr_cnt2 = wr & (idx == IDX_COUNTER_TWO) & unit_enable;
    assign wr_rel_a = wr & (idx == IDX_RELOAD_A) & unit_enable;
    assign wr_rel_b = wr & (idx == IDX_RELOAD_B) & unit_enable;
    assign wr_mode = wr & (idx == IDX_MODE_CTRL);
    assign wr_irq = wr & (idx == IDX_IRQ_CTRL);
    assign wr_clr = wr & (idx == IDX_IRQ_CLEAR);

    // ****************************************************************
    // Pin roles and edge detection
    // ****************************************************************
    logic pin_a_is_output;
    logic edge_a;
    logic edge_b;
    logic capture_a;
    logic capture_b1;
    logic capture_b2;

    // Pin A drives only while enabled and not used for capture
    assign pin_a_is_output = unit_enable & pin_a_enable & (mode != MODE_DUAL_CAPTURE);
    assign pin_a_oe = pin_a_is_output;
    assign pin_a_o = pin_a_is_output & pin_a_output_level;

    // Polarity picks which transition counts
    assign edge_a = pin_a_edge_polarity ? (pin_a_i & ~pin_a_prev_q)
                                        : (~pin_a_i & pin_a_prev_q);
    assign edge_b = pin_b_edge_polarity ? (pin_b_i & ~pin_b_prev_q)
                                        : (~pin_b_i & pin_b_prev_q);

    // Captures need the pin enabled; pin B enable matters only in capture modes
    assign capture_a = unit_enable & pin_a_enable & (mode == MODE_DUAL_CAPTURE) & edge_a;
    assign capture_b1 = unit_enable & pin_b_enable & (mode == MODE_DUAL_CAPTURE) & edge_b;
    assign capture_b2 = unit_enable & pin_b_enable & (mode == MODE_SINGLE_CAPTURE) & edge_b;

    // Previous pin levels for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a_prev_q <= 1'b0;
            pin_b_prev_q <= 1'b0;
        end else begin
            pin_a_prev_q <= pin_a_i;
            pin_b_prev_q <= pin_b_i;
        end
    end

    // ****************************************************************
    // Prescaler and counter ticks
    // ****************************************************************
    logic presc_tick;
    logic tick_one;
    logic tick_two;

    // Prescaler divides by divisor plus one; held at zero while halted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_cnt_q <= '0;
        end else if (!unit_enable || prescale_cnt_q >= prescale_divisor_q) begin
            prescale_cnt_q <= '0;
        end else begin
            prescale_cnt_q <= prescale_cnt_q + 1'b1;
        end
    end
    assign presc_tick = unit_enable & (prescale_cnt_q >= prescale_divisor_q);

    // Pin B is a clock input only in the two modes that do not capture on it
    function automatic logic pick_tick(input clk_sel_e sel, input logic b_clk_ok);
        logic t;
        t = 1'b0;
        unique case (sel)
            CLK_PRESCALED: t = presc_tick;
            CLK_PIN_B_EVENT: t = b_clk_ok & edge_b;
            CLK_PULSE_ACC: t = b_clk_ok & presc_tick & (pin_b_i == pin_b_edge_polarity);
            CLK_SLOW: t = slow_tick;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    logic b_clk_ok;
    assign b_clk_ok = (mode == MODE_PWM) || (mode == MODE_DUAL_COUNTER);
    // Process, not assigns: the function reads tick sources that are not its arguments
    always_comb begin
        tick_one = unit_enable & pick_tick(sel_one, b_clk_ok);
        tick_two = unit_enable & pick_tick(sel_two, b_clk_ok);
    end

    // ****************************************************************
    // Counters and reload/capture registers
    // ****************************************************************
    logic under_one;
    logic under_two;
    logic reload_one_from_b;

    assign under_one = tick_one & (counter_one_q == 16'h0000);
    assign under_two = tick_two & (counter_two_q == 16'h0000);
    // PWM alternates the reload source so A and B set the two half periods
    assign reload_one_from_b = (mode == MODE_PWM) & reload_b_next_q;

    // Counter one: software write wins over hardware activity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_one_q <= '0;
        end else if (wr_cnt1) begin
            counter_one_q <= pwdata[15:0];
        end else if (capture_a || capture_b1) begin
            counter_one_q <= PRESET_VALUE;
        end else if (under_one) begin
            if (mode == MODE_DUAL_CAPTURE) begin
                counter_one_q <= PRESET_VALUE;
            end else begin
                counter_one_q <= reload_one_from_b ? reload_b_q : reload_a_q;
            end
        end else if (tick_one) begin
            counter_one_q <= counter_one_q - 1'b1;
        end
    end

    // Tracks which reload register counter one takes next in PWM
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_b_next_q <= 1'b0;
        end else if (mode != MODE_PWM) begin
            reload_b_next_q <= 1'b0;
        end else if (under_one) begin
            reload_b_next_q <= ~reload_b_next_q;
        end
    end

    // Counter two: system timer, or second counter in dual counter mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_two_q <= '0;
        end else if (wr_cnt2) begin
            counter_two_q <= pwdata[15:0];
        end else if (capture_b2) begin
            counter_two_q <= PRESET_VALUE;
        end else if (under_two) begin
            counter_two_q <= (mode == MODE_DUAL_COUNTER) ? reload_b_q : PRESET_VALUE;
        end else if (tick_two) begin
            counter_two_q <= counter_two_q - 1'b1;
        end
    end

    // Reload/capture registers take counter values on pin captures
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_a_q <= '0;
        end else if (wr_rel_a) begin
            reload_a_q <= pwdata[15:0];
        end else if (capture_a) begin
            reload_a_q <= counter_one_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_b_q <= '0;
        end else if (wr_rel_b) begin
            reload_b_q <= pwdata[15:0];
        end else if (capture_b1) begin
            reload_b_q <= counter_one_q;
        end else if (capture_b2) begin
            reload_b_q <= counter_two_q;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic level_toggle;
    assign level_toggle = pin_a_is_output & under_one;

    // Mode control; level bit toggles in hardware unless software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ctrl_q <= MODE_CTRL_RST;
        end else if (wr_mode) begin
            mode_ctrl_q <= pwdata[7:0];
        end else if (level_toggle) begin
            mode_ctrl_q[LEVEL_A_BIT] <= ~pin_a_output_level;
        end
    end

    // Prescaler divisor and clock selects are writable at any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_divisor_q <= '0;
            clk_sel_q <= '0;
        end else if (wr && idx == IDX_PRESCALE) begin
            prescale_divisor_q <= pwdata[PRESCALE_W-1:0];
        end else if (wr && idx == IDX_CLOCK_SEL) begin
            clk_sel_q <= pwdata[2*SEL_W-1:0];
        end
    end

    // ****************************************************************
    // Interrupt enables and pending bits
    // ****************************************************************
    logic [3:0] hw_set;
    logic [3:0] sw_set;
    logic [3:0] sw_clr;

    // Source conditions per mode; C exists only in dual capture
    always_comb begin
        hw_set = 4'h0;
        unique case (mode)
            MODE_PWM: begin
                hw_set[0] = under_one & ~reload_one_from_b;
                hw_set[1] = under_one & reload_one_from_b;
                hw_set[3] = under_two;
            end
            MODE_DUAL_CAPTURE: begin
                hw_set[0] = capture_a;
                hw_set[1] = capture_b1;
                hw_set[2] = under_one;
                hw_set[3] = under_two;
            end
            MODE_DUAL_COUNTER: begin
                hw_set[0] = under_one;
                hw_set[3] = under_two;
            end
            MODE_SINGLE_CAPTURE: begin
                hw_set[0] = under_one;
                hw_set[1] = capture_b2;
                hw_set[3] = under_two;
            end
        endcase
    end

    // Only ones written to pending bits count; zeros are ignored
    assign sw_set = (wr_irq && unit_enable) ? pwdata[3:0] : 4'h0;
    assign sw_clr = wr_clr ? pwdata[3:0] : 4'h0;

    // A set in the same cycle as a clear wins so no event is lost
    always_comb begin
        if (!unit_enable) begin
            pend_d = 4'h0;
        end else begin
            pend_d = (pend_q & ~sw_clr) | hw_set | sw_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= IRQ_CTRL_RST[3:0];
        end else begin
            pend_q <= pend_d;
        end
    end

    // Enable half of the interrupt control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= IRQ_CTRL_RST;
        end else if (wr_irq) begin
            irq_en_q <= {pwdata[7:4], 4'h0};
        end
    end

    // Requests need both enable and pending
    assign irq_timer1 = |(pend_q[2:0] & irq_en_q[6:4]);
    assign irq_timer2 = pend_q[3] & irq_en_q[7];

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Read data registered from the setup phase so it stands in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr[ADDR_W-1:2])
                IDX_COUNTER_ONE: prdata <= {16'h0000, counter_one_q};
                IDX_COUNTER_TWO: prdata <= {16'h0000, counter_two_q};
                IDX_RELOAD_A: prdata <= {16'h0000, reload_a_q};
                IDX_RELOAD_B: prdata <= {16'h0000, reload_b_q};
                IDX_PRESCALE: prdata <= {27'h0, prescale_divisor_q};
                IDX_CLOCK_SEL: prdata <= {26'h0, clk_sel_q};
                IDX_MODE_CTRL: prdata <= {24'h0, mode_ctrl_q};
                IDX_IRQ_CTRL: prdata <= {24'h0, irq_en_q[7:4], pend_q};
                IDX_IRQ_CLEAR: prdata <= {24'h0, IRQ_CLEAR_READ};
                default: prdata <= '0;
            endcase
        end
    end

    logic unused_rd;
    assign unused_rd = rd;

endmodule

// >>> sim/timer_mode_and_irq_control_props.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checker
// ****************************************************************
module timer_mode_and_irq_control_props (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Direction
    input wire logic [mft_pkg::ADDR_W-1:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic pin_a_o, // Pin A drive
    input wire logic pin_a_oe, // Pin A enable
    input wire logic irq_timer1, // Request one
    input wire logic irq_timer2 // Request two
);
    import mft_pkg::*;
    logic [7:0] mode_q;
    logic [3:0] ien_q;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic mapped;
    // Decode; only even indices in the window carry registers
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign idx = paddr[ADDR_W-1:2];
    assign mapped = idx inside {IDX_COUNTER_ONE, IDX_RELOAD_A, IDX_RELOAD_B, IDX_COUNTER_TWO, IDX_PRESCALE,
        IDX_CLOCK_SEL, IDX_MODE_CTRL, IDX_IRQ_CTRL, IDX_IRQ_CLEAR};
    // Shadow of mode bits; the readback check skips the level bit since hardware also moves it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_CTRL_RST;
        end else if (wr && idx == IDX_MODE_CTRL) begin
            mode_q <= pwdata[7:0];
        end
    end
    // Enables are written even while the unit is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_q <= 4'h0;
        end else if (wr && idx == IDX_IRQ_CTRL) begin
            ien_q <= pwdata[7:4];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence wr_mode_s;
        wr && idx == IDX_MODE_CTRL;
    endsequence
    sequence off_s;
        !mode_q[UNIT_EN_BIT] [*2];
    endsequence
    a_ready_high: assert property (psel |-> pready) else $error("ready low");
    a_err_unmapped: assert property (psel && penable |-> pslverr == !mapped) else $error("error flag wrong");
    a_unmapped_zero: assert property (rd && !mapped |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_clear_reads_ones: assert property (rd && idx == IDX_IRQ_CLEAR |-> prdata[7:0] == IRQ_CLEAR_READ)
        else $error("clear register readback wrong");
    a_mode_readback: assert property (rd && idx == IDX_MODE_CTRL |-> prdata[5:0] == mode_q[5:0])
        else $error("mode readback wrong");
    a_oe_from_mode: assert property (pin_a_oe == (mode_q[7] && mode_q[4] && mode_q[1:0] != 2'b01))
        else $error("pin A enable wrong");
    a_level_write_wins: assert property (wr_mode_s ##1 pin_a_oe |-> pin_a_o == $past(pwdata[6]))
        else $error("written level lost");
    a_input_no_drive: assert property (!pin_a_oe |-> !pin_a_o) else $error("level leaks");
    a_irq1_needs_en: assert property (irq_timer1 |-> |ien_q[2:0]) else $error("request one unmasked");
    a_irq2_needs_en: assert property (irq_timer2 |-> ien_q[3]) else $error("request two unmasked");
    a_off_no_irq: assert property (off_s |-> !irq_timer1 && !irq_timer2) else $error("request while off");
endmodule

// >>> sim/pin_drive_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Far side of the two timer pins
// ****************************************************************
module pin_drive_model (
    input wire logic pin_a_o, // Design drive value
    input wire logic pin_a_oe, // Design drive enable
    output logic pin_a_i, // Wire level of pin A
    output logic pin_b_i // Wire level of pin B
);
    logic a_q = 1'b1;
    logic b_q = 1'b0;
    // Wire resolves to the design while it drives, else to our source
    assign pin_a_i = pin_a_oe ? pin_a_o : a_q;
    assign pin_b_i = b_q;
    // Called just after a clock edge
    task automatic set_a(input logic v);
        a_q <= v;
    endtask
    task automatic set_b(input logic v);
        b_q <= v;
    endtask
endmodule

// >>> sim/test_timer_mode_and_irq_control.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
// ****************************************************************
// Bench
// ****************************************************************
module test_timer_mode_and_irq_control;
    import mft_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, err;
    logic pin_a_i, pin_a_o, pin_a_oe, pin_b_i, slow_tick, irq_timer1, irq_timer2;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, r, v;
    int bad_count = 0;
    int checks = 0;
    always #10 pclk = ~pclk;
    timer_mode_and_irq_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_a_i(pin_a_i), .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_i(pin_b_i), .slow_tick(slow_tick),
        .irq_timer1(irq_timer1), .irq_timer2(irq_timer2));
    pin_drive_model u_pins (.pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_a_i(pin_a_i), .pin_b_i(pin_b_i));
    // One transfer; held until ready is seen, then one idle edge
    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd_chk(input logic [7:0] i, input logic [31:0] e);
        apb(1'b0, i, 32'h0);
        `CHK(r, e)
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic test_done;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Whole run is a few hundred cycles; this cuts a hang short
    initial begin
        idle(20000);
        bad_count++;
        test_done;
    end
    initial begin
        {presetn, psel, penable, pwrite, slow_tick} = 5'h0;
        paddr = '0;
        pwdata = '0;
        idle(6);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(IDX_MODE_CTRL, 32'h0);
        rd_chk(IDX_IRQ_CTRL, 32'h0);
        rd_chk(IDX_IRQ_CLEAR, 32'hff);
        rd_chk(8'h41, 32'h0);
        `CHK(err, 1'b1)
        // Unit off: pending and counter writes ignored, enables kept
        apb(1'b1, IDX_IRQ_CTRL, 32'hff);
        rd_chk(IDX_IRQ_CTRL, 32'hf0);
        apb(1'b1, IDX_COUNTER_ONE, 32'h1234);
        rd_chk(IDX_COUNTER_ONE, 32'h0);
        apb(1'b1, IDX_MODE_CTRL, 32'h80);
        apb(1'b1, IDX_IRQ_CTRL, 32'h0f);
        rd_chk(IDX_IRQ_CTRL, 32'h0f);
        `CHK({irq_timer1, irq_timer2}, 2'b00)
        apb(1'b1, IDX_IRQ_CTRL, 32'hf0);
        rd_chk(IDX_IRQ_CTRL, 32'hff);
        `CHK({irq_timer1, irq_timer2}, 2'b11)
        apb(1'b1, IDX_IRQ_CLEAR, 32'h05);
        rd_chk(IDX_IRQ_CTRL, 32'hfa);
        apb(1'b1, IDX_IRQ_CLEAR, 32'h00);
        rd_chk(IDX_IRQ_CTRL, 32'hfa);
        apb(1'b1, IDX_IRQ_CTRL, 32'h80);
        `CHK({irq_timer1, irq_timer2}, 2'b01)
        apb(1'b1, IDX_MODE_CTRL, 32'h00);
        rd_chk(IDX_IRQ_CTRL, 32'h80);
        // Every mode, pin A enabled and disabled
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, IDX_MODE_CTRL, 32'h90 | m);
            rd_chk(IDX_MODE_CTRL, 32'h90 | m);
            `CHK(pin_a_oe, 1'(m != 1))
            apb(1'b1, IDX_MODE_CTRL, 32'h80 | m);
            `CHK(pin_a_oe, 1'b0)
        end
        apb(1'b1, IDX_MODE_CTRL, 32'hd0);
        `CHK(pin_a_o, 1'b1)
        apb(1'b1, IDX_MODE_CTRL, 32'h90);
        `CHK(pin_a_o, 1'b0)
        apb(1'b1, IDX_MODE_CTRL, 32'hd1);
        `CHK(pin_a_oe, 1'b0)
        // PWM run from the undivided clock
        apb(1'b1, IDX_MODE_CTRL, 32'h90);
        apb(1'b1, IDX_RELOAD_A, 32'h3);
        apb(1'b1, IDX_RELOAD_B, 32'h3);
        apb(1'b1, IDX_COUNTER_ONE, 32'h3);
        apb(1'b1, IDX_PRESCALE, 32'h0);
        apb(1'b1, IDX_CLOCK_SEL, 32'h1);
        for (int n = 0; n < 40 && pin_a_o !== 1'b1; n++) @(posedge pclk);
        `CHK(pin_a_o, 1'b1)
        apb(1'b0, IDX_IRQ_CTRL, 32'h0);
        `CHK(r[0], 1'b1)
        apb(1'b1, IDX_MODE_CTRL, 32'h10);
        `CHK(pin_a_oe, 1'b0)
        apb(1'b0, IDX_COUNTER_ONE, 32'h0);
        v = r;
        idle(20);
        rd_chk(IDX_COUNTER_ONE, v);
        rd_chk(IDX_IRQ_CTRL, 32'h80);
        apb(1'b1, IDX_CLOCK_SEL, 32'h0);
        // Dual capture, rising edges on pin A
        apb(1'b1, IDX_MODE_CTRL, 32'h95);
        apb(1'b1, IDX_COUNTER_ONE, 32'h10);
        u_pins.set_a(1'b0);
        idle(8);
        rd_chk(IDX_COUNTER_ONE, 32'h10);
        u_pins.set_a(1'b1);
        idle(8);
        rd_chk(IDX_COUNTER_ONE, 32'hffff);
        apb(1'b0, IDX_IRQ_CTRL, 32'h0);
        `CHK(r[0], 1'b1)
        // Single capture on pin B, disabled then enabled
        apb(1'b1, IDX_MODE_CTRL, 32'h8b);
        apb(1'b1, IDX_COUNTER_TWO, 32'h20);
        u_pins.set_b(1'b1);
        idle(8);
        rd_chk(IDX_COUNTER_TWO, 32'h20);
        u_pins.set_b(1'b0);
        apb(1'b1, IDX_MODE_CTRL, 32'hab);
        u_pins.set_b(1'b1);
        idle(8);
        rd_chk(IDX_COUNTER_TWO, 32'hffff);
        u_pins.set_b(1'b0);
        apb(1'b1, IDX_MODE_CTRL, 32'ha8);
        apb(1'b1, IDX_COUNTER_ONE, 32'h30);
        u_pins.set_b(1'b1);
        idle(8);
        rd_chk(IDX_COUNTER_ONE, 32'h30);
        // Counter two on the slow tick: three pulses, three steps down
        apb(1'b1, IDX_CLOCK_SEL, 32'h20);
        apb(1'b1, IDX_COUNTER_TWO, 32'h5);
        repeat (3) begin
            slow_tick <= 1'b1;
            @(posedge pclk);
            slow_tick <= 1'b0;
            @(posedge pclk);
        end
        rd_chk(IDX_COUNTER_TWO, 32'h2);
        // Second reset in mid-run brings the control registers back to zero
        presetn <= 1'b0;
        idle(2);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(IDX_MODE_CTRL, 32'h0);
        rd_chk(IDX_IRQ_CTRL, 32'h0);
        test_done;
    end
endmodule
bind timer_mode_and_irq_control timer_mode_and_irq_control_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .irq_timer1(irq_timer1),
    .irq_timer2(irq_timer2));
